// [common/raster_timing_pkg.sv]
`default_nettype none
package raster_timing_pkg;

	// Register indexes; the byte address is four times the index.
	localparam logic [7:0] IDX_VTOTAL_LOW      = 8'h20;
	localparam logic [7:0] IDX_VTOTAL_HIGH     = 8'h21;
	localparam logic [7:0] IDX_VDISP_END_LOW   = 8'h22;
	localparam logic [7:0] IDX_VDISP_END_HIGH  = 8'h23;
	localparam logic [7:0] IDX_VBLANK_ST_LOW   = 8'h24;
	localparam logic [7:0] IDX_VBLANK_ST_HIGH  = 8'h25;
	localparam logic [7:0] IDX_VBLANK_END_LOW  = 8'h26;
	localparam logic [7:0] IDX_VBLANK_END_HIGH = 8'h27;
	localparam logic [7:0] IDX_VSYNC_ST_LOW    = 8'h28;
	localparam logic [7:0] IDX_VSYNC_ST_HIGH   = 8'h29;
	localparam logic [7:0] IDX_VSYNC_END_BYTE  = 8'h2A;
	localparam logic [7:0] IDX_SPLIT_LOW       = 8'h2C;
	localparam logic [7:0] IDX_SPLIT_HIGH      = 8'h2D;
	localparam logic [7:0] IDX_CURSOR_X_LOW    = 8'h30;
	localparam logic [7:0] IDX_CURSOR_X_HIGH   = 8'h31;
	localparam logic [7:0] IDX_CURSOR_X_PRESET = 8'h32;
	localparam logic [7:0] IDX_CURSOR_Y_LOW    = 8'h33;
	localparam logic [7:0] IDX_CURSOR_Y_HIGH   = 8'h34;
	localparam logic [7:0] IDX_CURSOR_Y_PRESET = 8'h35;
	localparam logic [7:0] IDX_CURSOR_VIS      = 8'h36;
	localparam logic [7:0] IDX_LINE_STATUS     = 8'h3E;
	localparam logic [7:0] IDX_LINE_STATUS_HI  = 8'h3F;

	localparam int LINE_WIDTH   = 11;
	localparam int PRESET_WIDTH = 6;
	localparam int CURSOR_SIZE  = 64;
	localparam logic [5:0] CURSOR_LAST = 6'h3F;
	localparam int VIS_BIT      = 0;
	localparam int LEGACY_BIT   = 5;

	localparam logic [15:0] VTOTAL_RESET   = 16'h020C;
	localparam logic [15:0] VDISP_RESET    = 16'h01DF;
	localparam logic [15:0] VBLANK_ST_RESET = 16'h01DF;
	localparam logic [15:0] VBLANK_END_RESET = 16'h020C;
	localparam logic [15:0] VSYNC_ST_RESET = 16'h01E9;
	localparam logic [7:0]  VSYNC_END_RESET = 8'hEB;
	localparam logic [15:0] ZERO16_RESET   = 16'h0000;

endpackage
`default_nettype wire

// [rtl/raster_timing_unit.sv]
// Behaviour
// - Blanking end is an 11-bit line position; value n means line n+1.
// - Sync start value n puts the sync pulse start at line n+1.
// - Sync end register holds only the low byte; full end derived from start.
// - Reading sync end gives a value that restores the same behaviour.
// - Line compare value n ends the scrollable region after line n.
// - Cursor horizontal start value n places the cursor at pixel n.
// - Cursor vertical start value n places the first cursor row at line n.
// - Horizontal preset picks the first cursor column; output stops at column 63.
// - Vertical preset picks the first cursor row; output stops at row 63.
// - Visibility bit 0 shows the cursor when one, suppresses it when zero.
// - Frame length is vertical total plus one lines.
// - Display end value n ends the active picture after n+1 lines.
`default_nettype none
module raster_timing_unit
	import raster_timing_pkg::*;
#(
	parameter int PIXEL_WIDTH = 11
)(
	input  wire logic                   ref_clk,
	input  wire logic                   reset,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   line_start,
	input  wire logic                   pixel_start,
	input  wire logic [PIXEL_WIDTH-1:0] pixel_pos,
	output logic                        vblank,
	output logic                        vsync,
	output logic                        active_video,
	output logic                        scroll_region,
	output logic                        cursor_window,
	output logic [5:0]                  cursor_col,
	output logic [5:0]                  cursor_row
);

	logic [15:0] vtotal;
	logic [15:0] vdisp_end;
	logic [15:0] vblank_start;
	logic [15:0] vblank_end;
	logic [15:0] vsync_start;
	logic [7:0]  vsync_end_byte;
	logic [15:0] scroll_split;
	logic [15:0] cursor_x;
	logic [15:0] cursor_y;
	logic [5:0]  cursor_x_preset;
	logic [5:0]  cursor_y_preset;
	logic        cursor_visible;
	logic [LINE_WIDTH-1:0] line;
	logic        in_sync;
	logic        in_blank;
	logic        in_cursor_rows;
	logic [5:0]  row_index;
	logic        in_cursor_cols;
	logic [5:0]  col_index;

	// A line field value n refers to line n counted from zero; only the low 11 bits are kept.
	function automatic logic [LINE_WIDTH-1:0] line_of(input logic [15:0] value);
		line_of = value[LINE_WIDTH-1:0];
	endfunction

	wire [7:0]  index       = paddr[9:2];
	wire        setup_write = psel && penable && pwrite;
	wire        word_ok     = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
	wire [7:0]  wbyte       = pwdata[7:0];

	// Frame wraps after line vtotal, giving vtotal+1 lines.
	// frame length
	wire        frame_end   = (line == line_of(vtotal));
	wire [LINE_WIDTH-1:0] next_line = frame_end ? '0 : line + 1'b1;

	// Sync begins on the line after the programmed start value.
	// sync start
	wire        sync_on     = (next_line == line_of(vsync_start) + 1'b1);
	wire        sync_off    = (next_line[7:0] == vsync_end_byte + 8'h01);
	wire        blank_on    = (next_line == line_of(vblank_start) + 1'b1);
	wire        blank_off   = (next_line == line_of(vblank_end) + 1'b1);
	wire        next_active = (next_line <= line_of(vdisp_end));
	wire        next_scroll = (next_line <= line_of(scroll_split));
	wire        row_first   = (next_line == line_of(cursor_y));

	wire        row_last    = (row_index == CURSOR_LAST);
	wire        col_first   = pixel_start && (pixel_pos == cursor_x[PIXEL_WIDTH-1:0]);
	wire        col_last    = (col_index == CURSOR_LAST);
	wire        next_in_cols = col_first ? 1'b1 : (pixel_start && col_last) ? 1'b0
		: in_cursor_cols;
	wire [5:0]  next_col    = col_first ? cursor_x_preset
		: (pixel_start && in_cursor_cols && !col_last) ? col_index + 6'h01 : col_index;

	// The stored byte is returned as written, bit 5 included, so a read gives the same value back.
	// save and restore readback
	wire [7:0]  vsync_end_read = vsync_end_byte;

	logic [15:0] read_mux;
	always_comb
	begin
		case (index)
			IDX_VTOTAL_LOW:      read_mux = {8'h00, vtotal[7:0]};
			IDX_VTOTAL_HIGH:     read_mux = {8'h00, vtotal[15:8]};
			IDX_VDISP_END_LOW:   read_mux = {8'h00, vdisp_end[7:0]};
			IDX_VDISP_END_HIGH:  read_mux = {8'h00, vdisp_end[15:8]};
			IDX_VBLANK_ST_LOW:   read_mux = {8'h00, vblank_start[7:0]};
			IDX_VBLANK_ST_HIGH:  read_mux = {8'h00, vblank_start[15:8]};
			IDX_VBLANK_END_LOW:  read_mux = {8'h00, vblank_end[7:0]};
			IDX_VBLANK_END_HIGH: read_mux = {8'h00, vblank_end[15:8]};
			IDX_VSYNC_ST_LOW:    read_mux = {8'h00, vsync_start[7:0]};
			IDX_VSYNC_ST_HIGH:   read_mux = {8'h00, vsync_start[15:8]};
			IDX_VSYNC_END_BYTE:  read_mux = {8'h00, vsync_end_read};
			IDX_SPLIT_LOW:       read_mux = {8'h00, scroll_split[7:0]};
			IDX_SPLIT_HIGH:      read_mux = {8'h00, scroll_split[15:8]};
			IDX_CURSOR_X_LOW:    read_mux = {8'h00, cursor_x[7:0]};
			IDX_CURSOR_X_HIGH:   read_mux = {8'h00, cursor_x[15:8]};
			IDX_CURSOR_X_PRESET: read_mux = {10'h000, cursor_x_preset};
			IDX_CURSOR_Y_LOW:    read_mux = {8'h00, cursor_y[7:0]};
			IDX_CURSOR_Y_HIGH:   read_mux = {8'h00, cursor_y[15:8]};
			IDX_CURSOR_Y_PRESET: read_mux = {10'h000, cursor_y_preset};
			IDX_CURSOR_VIS:      read_mux = {15'h0000, cursor_visible};
			IDX_LINE_STATUS:     read_mux = {8'h00, line[7:0]};
			IDX_LINE_STATUS_HI:  read_mux = {5'h00, in_sync, in_blank, 6'h00,
				line[LINE_WIDTH-1:8]};
			default:             read_mux = 16'h0000;
		endcase
	end

	wire mapped = word_ok && (index >= IDX_VTOTAL_LOW) && (index <= IDX_LINE_STATUS_HI)
		&& (index != 8'h2B) && (index != 8'h2E) && (index != 8'h2F)
		&& (index != 8'h37) && (index < 8'h38 || index > 8'h3D);

	// Bus answers in the first access cycle, so pready is held high.
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= 1'b1;
			pslverr <= psel && !penable && !mapped;
			prdata  <= (psel && !penable && !pwrite && mapped) ? {16'h0000, read_mux}
				: 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			vtotal          <= VTOTAL_RESET;
			vdisp_end       <= VDISP_RESET;
			vblank_start    <= VBLANK_ST_RESET;
			vblank_end      <= VBLANK_END_RESET;
			vsync_start     <= VSYNC_ST_RESET;
			vsync_end_byte  <= VSYNC_END_RESET;
			scroll_split    <= ZERO16_RESET;
			cursor_x        <= ZERO16_RESET;
			cursor_y        <= ZERO16_RESET;
			cursor_x_preset <= 6'h00;
			cursor_y_preset <= 6'h00;
			cursor_visible  <= 1'b0;
		end
		else if (setup_write && mapped)
		begin
			case (index)
				IDX_VTOTAL_LOW:      vtotal[7:0]        <= wbyte;
				IDX_VTOTAL_HIGH:     vtotal[15:8]       <= wbyte;
				IDX_VDISP_END_LOW:   vdisp_end[7:0]     <= wbyte;
				IDX_VDISP_END_HIGH:  vdisp_end[15:8]    <= wbyte;
				IDX_VBLANK_ST_LOW:   vblank_start[7:0]  <= wbyte;
				IDX_VBLANK_ST_HIGH:  vblank_start[15:8] <= wbyte;
				IDX_VBLANK_END_LOW:  vblank_end[7:0]    <= wbyte;
				IDX_VBLANK_END_HIGH: vblank_end[15:8]   <= wbyte;
				IDX_VSYNC_ST_LOW:    vsync_start[7:0]   <= wbyte;
				IDX_VSYNC_ST_HIGH:   vsync_start[15:8]  <= wbyte;
				IDX_VSYNC_END_BYTE:  vsync_end_byte     <= wbyte;
				IDX_SPLIT_LOW:       scroll_split[7:0]  <= wbyte;
				IDX_SPLIT_HIGH:      scroll_split[15:8] <= wbyte;
				IDX_CURSOR_X_LOW:    cursor_x[7:0]      <= wbyte;
				IDX_CURSOR_X_HIGH:   cursor_x[15:8]     <= wbyte;
				IDX_CURSOR_X_PRESET: cursor_x_preset    <= wbyte[PRESET_WIDTH-1:0];
				IDX_CURSOR_Y_LOW:    cursor_y[7:0]      <= wbyte;
				IDX_CURSOR_Y_HIGH:   cursor_y[15:8]     <= wbyte;
				IDX_CURSOR_Y_PRESET: cursor_y_preset    <= wbyte[PRESET_WIDTH-1:0];
				IDX_CURSOR_VIS:      cursor_visible     <= wbyte[VIS_BIT];
				default:             cursor_visible     <= cursor_visible;
			endcase
		end
	end

	// Vertical state advances once per line on the line_start strobe.
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			line           <= '0;
			in_sync        <= 1'b0;
			in_blank       <= 1'b0;
			in_cursor_rows <= 1'b0;
			row_index      <= 6'h00;
			active_video   <= 1'b0;
			scroll_region  <= 1'b0;
		end
		else if (line_start)
		begin
			line          <= next_line;
			active_video  <= next_active;
			scroll_region <= next_scroll;
			// On is tested first; a start whose low byte equals the end byte keeps sync on.
			in_sync       <= sync_on ? 1'b1 : sync_off ? 1'b0 : in_sync;
			in_blank      <= blank_on ? 1'b1 : blank_off ? 1'b0 : in_blank;
			if (row_first)
			begin
				in_cursor_rows <= 1'b1;
				row_index      <= cursor_y_preset;
			end
			else if (in_cursor_rows && row_last)
				in_cursor_rows <= 1'b0;
			else if (in_cursor_rows)
				row_index      <= row_index + 6'h01;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			in_cursor_cols <= 1'b0;
			col_index      <= 6'h00;
			cursor_window  <= 1'b0;
			cursor_col     <= 6'h00;
			cursor_row     <= 6'h00;
			vsync          <= 1'b0;
			vblank         <= 1'b0;
		end
		else
		begin
			in_cursor_cols <= line_start ? 1'b0 : next_in_cols;
			col_index      <= next_col;
			cursor_window  <= cursor_visible && in_cursor_rows && in_cursor_cols;
			cursor_col     <= col_index;
			cursor_row     <= row_index;
			vsync          <= in_sync;
			vblank         <= in_blank;
		end
	end

endmodule
`default_nettype wire

// [bench/raster_timing_unit_assertions.sv]
`default_nettype none
module raster_timing_unit_assertions
	import raster_timing_pkg::*;
#(
	parameter int PIXEL_WIDTH = 11
)(
	input wire logic                   ref_clk,
	input wire logic                   reset,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [11:0]            paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic                   line_start,
	input wire logic                   pixel_start,
	input wire logic [PIXEL_WIDTH-1:0] pixel_pos,
	input wire logic                   vblank,
	input wire logic                   vsync,
	input wire logic                   active_video,
	input wire logic                   scroll_region,
	input wire logic                   cursor_window,
	input wire logic [5:0]             cursor_col,
	input wire logic [5:0]             cursor_row
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire logic acc = psel && penable;
	sequence hide_write;
		acc && pwrite && pready && paddr == {2'b00, IDX_CURSOR_VIS, 2'b00} && !pwdata[0];
	endsequence
	AST_READY_AFTER_RESET: assert property ($past(!reset) |-> pready)
		else $error("pready low after reset release");
	AST_MISALIGNED_ERR: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access without error");
	AST_UNMAPPED_ERR: assert property (acc && paddr == 12'h0AC |-> pslverr)
		else $error("unmapped access without error");
	AST_MAPPED_OK: assert property (acc && paddr == {2'b00, IDX_CURSOR_VIS, 2'b00} |-> !pslverr)
		else $error("error on mapped access");
	AST_ERR_ZERO_DATA: assert property (pslverr |-> prdata == 32'h0000_0000)
		else $error("read data not zero on error");
	AST_COL_NO_WRAP: assert property (cursor_window && $past(cursor_window) |-> cursor_col > $past(cursor_col))
		else $error("cursor column wrapped or stalled");
	AST_ROW_STEADY: assert property (cursor_window && $past(cursor_window) |-> $stable(cursor_row))
		else $error("cursor row changed within a line");
	AST_HIDE: assert property (hide_write |-> ##[1:3] !cursor_window)
		else $error("cursor shown after visibility cleared");
	AST_RESET_QUIET: assert property (disable iff (1'b0) reset |=> !vsync && !vblank && !cursor_window)
		else $error("outputs active after reset");
endmodule
bind raster_timing_unit raster_timing_unit_assertions #(.PIXEL_WIDTH(PIXEL_WIDTH)) u_chk (
	.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.line_start(line_start), .pixel_start(pixel_start), .pixel_pos(pixel_pos),
	.vblank(vblank), .vsync(vsync), .active_video(active_video),
	.scroll_region(scroll_region), .cursor_window(cursor_window),
	.cursor_col(cursor_col), .cursor_row(cursor_row)
);
`default_nettype wire

// [bench/line_source.sv]
`default_nettype none
module line_source #(
	parameter int PIXEL_WIDTH = 11,
	parameter int LINE_PIXELS = 16
)(
	input  wire logic                   ref_clk,
	input  wire logic                   reset,
	output logic                        line_start,
	output logic                        pixel_start,
	output logic [PIXEL_WIDTH-1:0]      pixel_pos
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic last = pixel_pos == PIXEL_WIDTH'(LINE_PIXELS - 1);
	// One pixel per cycle keeps line pulses far apart, above the two-cycle minimum.
	always_ff @(posedge ref_clk)
	begin
		pixel_start <= !reset;
		line_start <= !reset && last;
		pixel_pos <= (reset || last) ? '0 : pixel_pos + 1'b1;
	end
endmodule
`default_nettype wire

// [bench/tb_raster_timing_unit.sv]
`default_nettype none
module tb_raster_timing_unit import raster_timing_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LP = 16;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, line_start, pixel_start, err, vblank, vsync;
	logic        active_video, scroll_region, cursor_window;
	logic [10:0] pixel_pos;
	logic [5:0]  cursor_col, cursor_row, col0, row0;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          nv, nb, na, ns, nc;
	// Flag, index, byte: reset values first, then the test frame of ten lines.
	logic [16:0] rows [28] = '{17'h02AEB, 17'h0260C, 17'h02702, 17'h028E9, 17'h02901,
		17'h03600, 17'h03200, 17'h12009, 17'h12100, 17'h12205, 17'h12300, 17'h12407,
		17'h12500, 17'h12601, 17'h12700, 17'h12803, 17'h12900, 17'h12A05, 17'h12C03,
		17'h12D07, 17'h12D00, 17'h13002, 17'h13100, 17'h1323C, 17'h13301, 17'h13400,
		17'h1353E, 17'h13601};
	line_source u_src (.ref_clk(ref_clk), .reset(reset), .line_start(line_start),
		.pixel_start(pixel_start), .pixel_pos(pixel_pos));
	raster_timing_unit dut_u (.ref_clk(ref_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .line_start(line_start),
		.pixel_start(pixel_start), .pixel_pos(pixel_pos), .vblank(vblank), .vsync(vsync),
		.active_video(active_video), .scroll_region(scroll_region),
		.cursor_window(cursor_window), .cursor_col(cursor_col), .cursor_row(cursor_row));
	always #5 ref_clk = ~ref_clk;
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		input logic [1:0] lo = 2'b00);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, lo};
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Any window of one frame length holds each per-line level the same number of cycles.
	task automatic measure();
		nv = 0;
		nb = 0;
		na = 0;
		ns = 0;
		nc = 0;
		repeat (200) @(posedge ref_clk);
		// Start once vsync is seen high so the cursor rows of one frame fall wholly inside.
		do
		begin
			@(posedge ref_clk);
		end
		while (vsync !== 1'b1);
		repeat (10 * LP)
		begin
			@(posedge ref_clk);
			nv += (vsync === 1'b1);
			nb += (vblank === 1'b1);
			na += (active_video === 1'b1);
			ns += (scroll_region === 1'b1);
			if (cursor_window === 1'b1 && nc++ == 0)
				{col0, row0} = {cursor_col, cursor_row};
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (4000) @(posedge ref_clk);
		n_mismatch++;
		print_verdict();
	end
	initial
	begin
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		foreach (rows[i])
		begin
			if (rows[i][16])
				apb(1'b1, rows[i][15:8], rows[i][7:0]);
			apb(1'b0, rows[i][15:8], 8'h00);
			check("register", rd, {24'h0, rows[i][7:0]});
			check("error", {31'h0, err}, 32'h0);
		end
		$display("test registers done");
		apb(1'b0, 8'h2B, 8'h00);
		check("unmapped error", {31'h0, err}, 32'h1);
		check("unmapped data", rd, 32'h0);
		apb(1'b1, IDX_SPLIT_LOW, 8'h07, 2'b01);
		check("misaligned error", {31'h0, err}, 32'h1);
		apb(1'b0, IDX_SPLIT_LOW, 8'h00);
		check("misaligned ignored", rd, 32'h3);
		$display("test refusals done");
		measure();
		check("vsync lines", nv, LP * (5 - 3));
		check("vblank lines", nb, LP * (10 - 8 + 2));
		check("active lines", na, LP * (5 + 1));
		check("scroll lines", ns, LP * (3 + 1));
		check("cursor pixels", nc, (64 - 60) * (64 - 62));
		check("first column", col0, 32'h3C);
		check("first row", row0, 32'h3E);
		$display("test frame done");
		// Software hides the cursor before any access to its image.
		// hide before image access
		apb(1'b1, IDX_CURSOR_VIS, 8'h00);
		measure();
		check("hidden cursor", nc, 0);
		$display("test hide done");
		// Bit 5 set before a legacy mode switch; end stays within 256 lines of start.
		apb(1'b1, IDX_VSYNC_END_BYTE, 8'h22);
		apb(1'b0, IDX_VSYNC_END_BYTE, 8'h00);
		check("sync end bit 5", rd, 32'h22);
		$display("test legacy bit done");
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		apb(1'b0, IDX_VSYNC_END_BYTE, 8'h00);
		check("reset sync end", rd, 32'hEB);
		apb(1'b0, IDX_CURSOR_VIS, 8'h00);
		check("reset visibility", rd, 32'h0);
		check("reset vsync", {31'h0, vsync}, 32'h0);
		$display("test reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
